// ===== ciod_exec.v
// Purpose: Execution of interrupt response, save, push, return, port I/O,
//          DMA byte cycles and accumulator shifts.
// Assumes: One clock pclk at 25 MHz; pins are synchronised here.
// Notes:   Registers over APB; memory is held inside the block.
`timescale 1ns/1ps
`include "ciod_defines.vh"
// Operation
// - Interrupt copies P to low nibble, X to high nibble of T.
// - Interrupt loads P with 1 and X with 2.
// - Interrupt clears the interrupt gate.
// - Interrupt cycle drives its own state code.
// - Opcode 78 stores T at memory addressed by R(X).
// - Opcode 79 stores X,P via T at R(2), then X gets P, R(2) decrements.
// - Opcode 70 loads X,P from M(R(X)), increments R(X), sets gate.
// - Opcode 71 is like 70 but clears the gate.
// - Interrupt request is ignored while the gate is zero.
// - Opcodes 61-67 put M(R(X)) on the bus and increment R(X).
// - Port lines show opcode low bits only during I/O, else low.
// - Opcodes 69-6F write bus byte to M(R(X)) and D; R(X) kept.
// - DMA-in stores bus at M(R(0)); DMA-out drives M(R(0)); R(0) increments.
// - Priority is DMA-in, then DMA-out, then interrupt.
// - Output with X equal to P sends the byte after the opcode.
// - F6 and FE shift D right or left, filling zero.
// - 76 and 7E rotate D through the carry flag.
module ciod_exec #(
  parameter AW = 8
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        dma_in_req,
  input  wire        dma_out_req,
  input  wire        irq_req,
  input  wire [7:0]  bus_i,
  output reg  [7:0]  bus_o,
  output reg         bus_oe,
  output reg  [2:0]  port_sel,
  output reg         memory_read_strobe_n,
  output reg  [1:0]  state_code
);
  localparam ST_BND = 3'h0;
  localparam ST_EXE = 3'h1;
  localparam ST_DMI = 3'h2;
  localparam ST_DMO = 3'h3;
  localparam ST_INT = 3'h4;
  localparam DEPTH  = 1 << AW;

  reg [7:0]    mem_q [0:DEPTH-1];
  reg [15:0]   r_q [0:15];
  reg [2:0]    st_q;
  reg [7:0]    op_q;
  reg [1:0]    wc_q;
  reg [3:0]    p_q;
  reg [3:0]    x_q;
  reg [7:0]    t_q;
  reg [7:0]    d_q;
  reg          carry_flag_q;
  reg          irq_gate_q;
  reg          run_q;
  reg [AW-1:0] maddr_q;
  reg [2:0]    req_m_q;
  reg [2:0]    req_s_q;
  reg [7:0]    bus_m_q;
  reg [7:0]    bus_s_q;
  reg          mem_we;
  reg [AW-1:0] mem_wa;
  reg [7:0]    mem_wd;
  integer      i;

  wire          acc    = psel & penable & pready;
  wire          io_op  = (op_q[7:4] == `CIOD_GRP_IO);
  wire          in_op  = io_op & op_q[3] & (op_q[2:0] != 3'h0);
  wire          out_op = io_op & ~op_q[3] & (op_q[2:0] != 3'h0);
  wire [AW-1:0] ax     = r_q[x_q][AW-1:0];
  wire [AW-1:0] a0     = r_q[`CIOD_DMA_R][AW-1:0];
  wire [AW-1:0] a2     = r_q[`CIOD_STACK_R][AW-1:0];
  wire [15:0]   rp1    = r_q[p_q] + 16'h0001;
  wire [7:0]    fb     = mem_q[r_q[p_q][AW-1:0]];
  wire [AW-1:0] ax_f   = (x_q == p_q) ? rp1[AW-1:0] : ax;
  wire          synced = (wc_q == `CIOD_SYNC_WAIT);

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_m_q <= 3'h0;
      req_s_q <= 3'h0;
      bus_m_q <= 8'h00;
      bus_s_q <= 8'h00;
    end
    else if (ce)
    begin
      req_m_q <= {irq_req, dma_out_req, dma_in_req};
      req_s_q <= req_m_q;
      bus_m_q <= bus_i;
      bus_s_q <= bus_m_q;
    end
  end

  // -----------------------------------------------------------------
  // Memory write port
  // -----------------------------------------------------------------
  always @*
  begin
    mem_we = 1'b0;
    mem_wa = maddr_q;
    mem_wd = pwdata[7:0];
    if (st_q == ST_EXE && op_q == `CIOD_OP_SAVE)
    begin
      mem_we = 1'b1;
      mem_wa = ax;
      mem_wd = t_q;
    end
    else if (st_q == ST_EXE && op_q == `CIOD_OP_MARK)
    begin
      mem_we = 1'b1;
      mem_wa = a2;
      mem_wd = {x_q, p_q};
    end
    else if (st_q == ST_EXE && in_op && synced)
    begin
      mem_we = 1'b1;
      mem_wa = ax;
      mem_wd = bus_s_q;
    end
    else if (st_q == ST_DMI && synced)
    begin
      mem_we = 1'b1;
      mem_wa = a0;
      mem_wd = bus_s_q;
    end
    else if (acc && pwrite && paddr == `CIOD_OFF_MDATA)
    begin
      mem_we = 1'b1;
    end
  end

  always @(posedge pclk)
  begin
    if (ce && mem_we)
      mem_q[mem_wa] <= mem_wd;
  end

  // -----------------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      run_q   <= 1'b0;
      maddr_q <= {AW{1'b0}};
    end
    else if (ce)
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready)
      begin
        prdata <= 32'h00000000;
        case (paddr)
          `CIOD_OFF_CTRL:  prdata[`CIOD_CTRL_RUN] <= run_q;
          `CIOD_OFF_STAT:  prdata <= {d_q, 6'h00, carry_flag_q, irq_gate_q, t_q, x_q, p_q};
          `CIOD_OFF_MADDR: prdata[AW-1:0] <= maddr_q;
          `CIOD_OFF_MDATA: prdata[7:0] <= mem_q[maddr_q];
          default:         pslverr <= 1'b1;
        endcase
      end
      if (acc && pwrite && paddr == `CIOD_OFF_CTRL)
        run_q <= pwdata[`CIOD_CTRL_RUN];
      if (acc && pwrite && paddr == `CIOD_OFF_MADDR)
        maddr_q <= pwdata[AW-1:0];
    end
  end

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q                 <= ST_BND;
      op_q                 <= 8'h00;
      wc_q                 <= 2'h0;
      p_q                  <= `CIOD_RST_SEL;
      x_q                  <= `CIOD_RST_SEL;
      t_q                  <= 8'h00;
      d_q                  <= 8'h00;
      carry_flag_q         <= 1'b0;
      irq_gate_q           <= `CIOD_RST_GATE;
      bus_o                <= 8'h00;
      bus_oe               <= 1'b0;
      port_sel             <= 3'h0;
      memory_read_strobe_n <= 1'b1;
      state_code           <= `CIOD_SC_FETCH;
      for (i = 0; i < 16; i = i + 1)
        r_q[i] <= 16'h0000;
    end
    else if (ce)
    begin
      case (st_q)
        ST_BND:
        begin
          wc_q <= 2'h0;
          if (!run_q)
            st_q <= ST_BND;
          else if (req_s_q[0])
          begin
            st_q       <= ST_DMI;
            state_code <= `CIOD_SC_DMA;
          end
          else if (req_s_q[1])
          begin
            st_q                 <= ST_DMO;
            state_code           <= `CIOD_SC_DMA;
            bus_o                <= mem_q[a0];
            bus_oe               <= 1'b1;
            memory_read_strobe_n <= 1'b0;
          end
          else if (req_s_q[2] && irq_gate_q)
          begin
            st_q       <= ST_INT;
            state_code <= `CIOD_SC_INT;
          end
          else
          begin
            op_q       <= fb;
            r_q[p_q]   <= rp1;
            st_q       <= ST_EXE;
            state_code <= `CIOD_SC_EXEC;
            if (fb[7:4] == `CIOD_GRP_IO)
            begin
              port_sel <= fb[2:0];
              if (!fb[3] && fb[2:0] != 3'h0)
              begin
                bus_o                <= mem_q[ax_f];
                bus_oe               <= 1'b1;
                memory_read_strobe_n <= 1'b0;
              end
            end
          end
        end
        ST_EXE:
        begin
          st_q <= ST_BND;
          case (op_q)
            `CIOD_OP_MARK:
            begin
              t_q                   <= {x_q, p_q};
              x_q                   <= p_q;
              r_q[`CIOD_STACK_R]    <= r_q[`CIOD_STACK_R] - 16'h0001;
            end
            `CIOD_OP_RETEN, `CIOD_OP_RETDIS:
            begin
              {x_q, p_q} <= mem_q[ax];
              r_q[x_q]   <= r_q[x_q] + 16'h0001;
              irq_gate_q <= ~op_q[0];
            end
            `CIOD_OP_RIGHT_SHIFT:  {d_q, carry_flag_q} <= {1'b0, d_q};
            `CIOD_OP_LEFT_SHIFT:   {carry_flag_q, d_q} <= {d_q, 1'b0};
            `CIOD_OP_RIGHT_ROTATE: {d_q, carry_flag_q} <= {carry_flag_q, d_q};
            `CIOD_OP_LEFT_ROTATE:  {carry_flag_q, d_q} <= {d_q, carry_flag_q};
            default:
            begin
              if (out_op)
              begin
                r_q[x_q] <= r_q[x_q] + 16'h0001;
              end
              else if (in_op && !synced)
              begin
                wc_q <= wc_q + 2'h1;
                st_q <= ST_EXE;
              end
              else if (in_op)
              begin
                d_q <= bus_s_q;
              end
            end
          endcase
        end
        ST_DMI:
        begin
          if (!synced)
          begin
            wc_q <= wc_q + 2'h1;
          end
          else
          begin
            r_q[`CIOD_DMA_R] <= r_q[`CIOD_DMA_R] + 16'h0001;
            st_q             <= ST_BND;
          end
        end
        ST_DMO:
        begin
          r_q[`CIOD_DMA_R] <= r_q[`CIOD_DMA_R] + 16'h0001;
          st_q             <= ST_BND;
        end
        ST_INT:
        begin
          t_q        <= {x_q, p_q};
          p_q        <= `CIOD_INT_P;
          x_q        <= `CIOD_INT_X;
          irq_gate_q <= 1'b0;
          st_q       <= ST_BND;
        end
        default:
          st_q <= ST_BND;
      endcase
      if (st_q != ST_BND && !(st_q == ST_EXE && in_op && !synced) && !(st_q == ST_DMI && !synced))
      begin
        state_code           <= `CIOD_SC_FETCH;
        port_sel             <= 3'h0;
        bus_oe               <= 1'b0;
        bus_o                <= 8'h00;
        memory_read_strobe_n <= 1'b1;
      end
    end
  end
endmodule

// ===== ciod_defines.vh
// Purpose: Constants for the interrupt, I/O and DMA execution block.
// Assumes: Included by ciod_exec.v only.
// Notes:   Byte offsets on a 32-bit APB data path.
`ifndef CIOD_DEFINES_VH
`define CIOD_DEFINES_VH
// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define CIOD_OFF_CTRL  8'h00
`define CIOD_OFF_STAT  8'h04
`define CIOD_OFF_MADDR 8'h08
`define CIOD_OFF_MDATA 8'h0c
// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define CIOD_CTRL_RUN  0
`define CIOD_STAT_P_LO 0
`define CIOD_STAT_X_LO 4
`define CIOD_STAT_T_LO 8
`define CIOD_STAT_GATE  16
`define CIOD_STAT_CARRY 17
`define CIOD_STAT_D_LO  24
`define CIOD_RST_GATE   1'b1
`define CIOD_RST_SEL   4'h0
// -----------------------------------------------------------------
// Opcodes and groups
// -----------------------------------------------------------------
`define CIOD_OP_SAVE   8'h78
`define CIOD_OP_MARK   8'h79
`define CIOD_OP_RETEN  8'h70
`define CIOD_OP_RETDIS 8'h71
`define CIOD_OP_RIGHT_SHIFT  8'hf6
`define CIOD_OP_LEFT_SHIFT   8'hfe
`define CIOD_OP_RIGHT_ROTATE 8'h76
`define CIOD_OP_LEFT_ROTATE  8'h7e
`define CIOD_GRP_IO    4'h6
`define CIOD_INT_P     4'h1
`define CIOD_INT_X     4'h2
`define CIOD_STACK_R   4'h2
`define CIOD_DMA_R     4'h0
// -----------------------------------------------------------------
// State codes and timing
// -----------------------------------------------------------------
`define CIOD_SC_FETCH  2'h0
`define CIOD_SC_EXEC   2'h1
`define CIOD_SC_DMA    2'h2
`define CIOD_SC_INT    2'h3
`define CIOD_SYNC_WAIT 2'h2
`endif

// ===== ciod_exec_asserts.sv
// Purpose: Port checks for the execution block.
// Assumes: Clock enable held high.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
module ciod_exec_asserts (
  input wire       pclk,
  input wire       presetn,
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       pslverr,
  input wire       bus_oe,
  input wire       memory_read_strobe_n,
  input wire [2:0] port_sel,
  input wire [1:0] state_code
);
  // ------------------------------
  // Checks
  // ------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_port_quiet: assert property (state_code != 2'h1 |-> port_sel == 3'h0)
    else $error("port lines active outside execute");
  chk_int_once: assert property (state_code == 2'h3 |=> state_code == 2'h0)
    else $error("interrupt cycle too long");
  chk_int_entry: assert property (state_code == 2'h3 |-> $past(state_code) == 2'h0)
    else $error("interrupt not entered from a boundary");
  chk_out_single: assert property (state_code == 2'h1 && bus_oe |=> state_code == 2'h0 && !bus_oe)
    else $error("output transfer not one cycle");
  chk_drive_strobe: assert property (bus_oe |-> !memory_read_strobe_n)
    else $error("bus driven without read strobe");
  chk_in_span: assert property (
    state_code == 2'h1 && $past(state_code) == 2'h0 && port_sel != 3'h0 && !bus_oe
    |-> (state_code == 2'h1)[*3] ##1 state_code == 2'h0)
    else $error("input transfer length wrong");
  chk_dma_in_span: assert property (
    state_code == 2'h2 && $past(state_code) == 2'h0 && !bus_oe
    |-> (state_code == 2'h2 && !bus_oe)[*3] ##1 state_code == 2'h0)
    else $error("dma in length wrong");
  chk_dma_out_one: assert property (state_code == 2'h2 && bus_oe |=> state_code == 2'h0)
    else $error("dma out length wrong");
  chk_apb_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  chk_err_pulse: assert property (pslverr |-> pready ##1 !pready)
    else $error("error response not a pulse");
endmodule
bind ciod_exec ciod_exec_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .bus_oe(bus_oe), .memory_read_strobe_n(memory_read_strobe_n),
  .port_sel(port_sel), .state_code(state_code));

// ===== ciod_periph_model.sv
// Purpose: Far-side peripheral for port input and dma in bytes.
// Assumes: One input device on port code IN_PORT.
// Notes:   A released bus shows the inverse of its last byte.
`timescale 1ns/1ps
module ciod_periph_model #(
  parameter logic [2:0] IN_PORT = 3'h1
) (
  input  wire logic       pclk,
  input  wire logic [2:0] port_sel,
  input  wire logic [1:0] state_code,
  input  wire logic       memory_read_strobe_n,
  input  wire logic       bus_oe,
  input  wire logic [7:0] in_byte,
  output logic      [7:0] bus_i
);
  // ------------------------------
  // Bus drive
  // ------------------------------
  logic [7:0] last_q = 8'h00;
  logic       drv;
  assign drv = !bus_oe && memory_read_strobe_n &&
               ((state_code == 2'h1 && port_sel == IN_PORT) || state_code == 2'h2);
  assign bus_i = drv ? in_byte : ~last_q;
  always @(posedge pclk)
  begin
    if (drv)
      last_q <= in_byte;
  end
endmodule

// ===== ciod_exec_tb_top.sv
// Purpose: Self-checking bench for the execution block.
// Assumes: Clock enable tied high; programs loaded over APB.
// Notes:   Each program starts from reset and is stopped by the run bit.
`timescale 1ns/1ps
module ciod_exec_tb_top;
  // ------------------------------
  // Signals
  // ------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        dma_in_req = 1'b0;
  logic        dma_out_req = 1'b0;
  logic        irq_req = 1'b0;
  logic [7:0]  in_byte = 8'h00;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [7:0]  bus_i;
  wire  [7:0]  bus_o;
  wire         bus_oe;
  wire  [2:0]  port_sel;
  wire         memory_read_strobe_n;
  wire  [1:0]  state_code;
  logic [31:0] rd_q;
  logic        err_q;
  logic [1:0]  sc_q = 2'h0;
  logic [10:0] outs [$];
  logic [2:0]  kinds [$];
  logic [15:0] shp [0:2] = '{16'h7e7e, 16'hfef6, 16'h7676};
  int          n_int = 0;
  int          bad_count = 0;
  int          n_tests = 0;
  ciod_exec #(.AW(8)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_in_req(dma_in_req), .dma_out_req(dma_out_req), .irq_req(irq_req), .bus_i(bus_i), .bus_o(bus_o),
    .bus_oe(bus_oe), .port_sel(port_sel), .memory_read_strobe_n(memory_read_strobe_n), .state_code(state_code));
  ciod_periph_model u_periph (.pclk(pclk), .port_sel(port_sel), .state_code(state_code),
    .memory_read_strobe_n(memory_read_strobe_n), .bus_oe(bus_oe), .in_byte(in_byte), .bus_i(bus_i));
  initial
    forever #20 pclk = ~pclk;
  // ------------------------------
  // Monitor of action starts
  // ------------------------------
  always @(posedge pclk)
  begin
    sc_q <= state_code;
    if (state_code != 2'h0 && sc_q == 2'h0)
    begin
      if (bus_oe)
        outs.push_back({port_sel, bus_o});
      if (state_code[1] && (kinds.size() == 0 || kinds[$] !== {state_code, bus_oe}))
        kinds.push_back({state_code, bus_oe});
      if (state_code == 2'h3)
        n_int++;
    end
    if (state_code == 2'h2)
      if (bus_oe)
        dma_out_req <= 1'b0;
      else
        dma_in_req <= 1'b0;
  end
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic mw(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, 8'h08, {24'h0, a});
    apb(1'b1, 8'h0c, {24'h0, d});
  endtask
  task automatic mr(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b1, 8'h08, {24'h0, a});
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd_q, {24'h0, exp});
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic load(input logic [7:0] p [0:7]);
    do_reset();
    outs.delete();
    kinds.delete();
    n_int = 0;
    for (int k = 0; k < 8; k++)
      mw(k[7:0], p[k]);
  endtask
  task automatic go;
    apb(1'b1, 8'h00, 32'h1);
    repeat (150) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h0);
  endtask
  function automatic logic [8:0] sh(input logic [7:0] op, input logic [8:0] cd);
    case (op)
      8'hf6: sh = {cd[0], 1'b0, cd[7:1]};
      8'hfe: sh = {cd[7], cd[6:0], 1'b0};
      8'h76: sh = {cd[0], cd[8], cd[7:1]};
      default: sh = {cd[7], cd[6:0], cd[8]};
    endcase
  endfunction
  task tally_and_finish;
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #(40 * 10000);
    bad_count++;
    tally_and_finish();
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    logic [7:0]  p [0:7];
    logic [8:0]  e;
    logic [7:0]  b;
    logic [7:0]  r;
    logic [2:0]  n1;
    logic [2:0]  n2;
    logic [31:0] m;
    void'($urandom(32'h620f4fc7));
    do_reset();
    apb(1'b0, 8'h04, 32'h0);
    chk(rd_q, 32'h00010000);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd_q[30:0], err_q}, 32'h1);
    for (int i = 0; i < 256; i++)
      mw(i[7:0], 8'hc4);
    for (int i = 0; i < 3; i++)
    begin
      n1 = 3'($urandom_range(7, 1));
      n2 = 3'($urandom_range(7, 1));
      r = 8'($urandom);
      b = 8'($urandom);
      p = '{{5'h0c, n1}, r, 8'h70, 8'h40, {5'h0c, n2}, 8'h69, shp[i][15:8], shp[i][7:0]};
      load(p);
      in_byte <= b;
      go();
      e = sh(shp[i][7:0], sh(shp[i][15:8], {1'b0, b}));
      m = (i == 1) ? 32'h20000 : 32'h0;
      apb(1'b0, 8'h04, 32'h0);
      chk(rd_q | m, {e[7:0], 6'h0, e[8], 9'h100, 8'h40} | m);
      mr(8'h01, b);
      chk(outs.size(), 32'd2);
      chk({21'h0, outs[0]}, {21'h0, n1, r});
      chk({21'h0, outs[1]}, {21'h0, n2, 5'h0c, n1});
    end
    p = '{8'hc4, 8'h78, 8'hc4, 8'h71, 8'h11, 8'hc4, 8'hc4, 8'hc4};
    load(p);
    in_byte <= 8'h79;
    dma_in_req <= 1'b1;
    dma_out_req <= 1'b1;
    irq_req <= 1'b1;
    go();
    chk(kinds.size(), 32'd3);
    chk({23'h0, kinds[0], kinds[1], kinds[2]}, 32'h12e);
    chk(n_int, 32'd1);
    chk({21'h0, outs[0]}, 32'h078);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd_q, 32'h00002111);
    mr(8'h00, 8'h21);
    mr(8'h02, 8'h21);
    tally_and_finish();
  end
endmodule
